// [bench/dbg_link_chk.sv]
`timescale 1ns/100ps
`default_nettype none
module dbg_link_chk (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst,
	// watched ports
	input wire dbg_link_pkg::reg_req_t i_req,
	input wire logic [7:0] o_rdata,
	input wire logic i_sys_reset_nack_evt,
	input wire dbg_link_pkg::link_cfg_t o_cfg,
	input wire logic o_link_reset,
	input wire logic o_timeout_err,
	input wire logic o_send_nack,
	input wire logic o_sys_reset_req,
	input wire logic o_sys_clock_request
);
	import dbg_link_pkg::*;
	logic wr_r, wr_a, wr_b, wr_s;
	assign wr_r = i_req.wr && i_req.addr == ADDR_RST_REQ;
	assign wr_a = i_req.wr && i_req.addr == ADDR_CTRL_A;
	assign wr_b = i_req.wr && i_req.addr == ADDR_CTRL_B;
	assign wr_s = i_req.wr && i_req.addr == ADDR_SYS_CTRL;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);
	property p_rst_on; wr_r && i_req.wdata == RST_CODE_RESET |=> o_sys_reset_req; endproperty
	a_rst_on: assert property (p_rst_on) else $error("reset hold missing");
	property p_rst_off; wr_r && i_req.wdata != RST_CODE_RESET |=> !o_sys_reset_req; endproperty
	a_rst_off: assert property (p_rst_off) else $error("reset hold kept");
	property p_dis; wr_b && i_req.wdata[CB_DIS] |=> o_link_reset; endproperty
	a_dis: assert property (p_dis) else $error("link reset missing");
	property p_clk_off; wr_s && !i_req.wdata[SC_SYS_CLOCK_REQUEST] |=> !o_sys_clock_request; endproperty
	a_clk_off: assert property (p_clk_off) else $error("clock request kept");
	property p_gap; o_cfg.inter_byte_delay_en |-> o_cfg.idle_gap_bits == IBD_IDLE_BITS; endproperty
	a_gap: assert property (p_gap) else $error("idle gap wrong");
	property p_guard;
		wr_a && i_req.wdata[2:0] != GUARD_RESERVED |=> ##1
			o_cfg.guard_cycles == GUARD_MAX_CYCLES >> $past(i_req.wdata[2:0], 2);
	endproperty
	a_guard: assert property (p_guard) else $error("guard time wrong");
	property p_rev; i_req.rd && i_req.addr == ADDR_STATUS_REV |=> o_rdata[7:4] == LINK_REVISION; endproperty
	a_rev: assert property (p_rev) else $error("revision wrong");
	// both polarities in one: pulse must be the inverse of the disable bit
	property p_nack;
		i_sys_reset_nack_evt && $stable(o_cfg.neg_ack_off) |=> o_send_nack != $past(o_cfg.neg_ack_off);
	endproperty
	a_nack: assert property (p_nack) else $error("nack wrong");
	property p_to; o_cfg.timeout_check_off && $past(o_cfg.timeout_check_off) |-> !o_timeout_err; endproperty
	a_to: assert property (p_to) else $error("timeout while off");
	c_rst: cover property (wr_r ##1 o_sys_reset_req);
	c_dis: cover property (o_link_reset);
	c_to: cover property (o_timeout_err);
endmodule
bind dbg_link_regs dbg_link_chk dbg_link_chk_inst (.i_clk_sys, .i_rst, .i_req, .o_rdata,
	.i_sys_reset_nack_evt, .o_cfg, .o_link_reset, .o_timeout_err, .o_send_nack,
	.o_sys_reset_req, .o_sys_clock_request);
`default_nettype wire

// [bench/dbg_sys_model.sv]
`timescale 1ns/100ps
`default_nettype none
module dbg_sys_model (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst,
	// system-side stimulus
	input wire logic i_reset_hold,
	input wire logic i_sleep,
	input wire logic i_unlock,
	input wire logic [1:0] i_crc_sel,
	// status toward the link block
	output var dbg_link_pkg::sys_stat_t o_sys
);
	import dbg_link_pkg::*;
	// one cycle late on purpose, like a real cross-domain status path
	always_ff @(posedge i_clk_sys) begin
		o_sys.sys_in_reset <= i_reset_hold;
		o_sys.sys_in_sleep <= i_sleep;
		o_sys.locked <= i_rst | (o_sys.locked & !i_unlock);
		o_sys.crc_enabled <= i_crc_sel != 2'h0;
		o_sys.crc_busy <= i_crc_sel == 2'h1;
		o_sys.crc_done <= i_crc_sel[1];
		o_sys.crc_ok <= i_crc_sel == 2'h2;
	end
endmodule
`default_nettype wire

// [bench/test_dbg_link_regs.sv]
`timescale 1ns/100ps
`default_nettype none
module test_dbg_link_regs;
	import dbg_link_pkg::*;
	logic i_clk_sys = 1'b0, i_rst = 1'b1, pend = 1'b0, done = 1'b0, nack = 1'b0;
	logic sleep = 1'b0, unlock = 1'b0, to_seen = 1'b0;
	logic [1:0] crc = 2'h0;
	reg_req_t i_req = '0;
	link_evt_t i_evt = '0;
	sys_stat_t i_sys;
	link_cfg_t o_cfg;
	logic [7:0] o_rdata, v;
	logic o_link_reset, o_timeout_err, o_send_nack, o_sys_reset_req, o_sys_clock_request;
	logic o_user_row_done, o_mem_prog_ok, o_user_row_prog_ok;
	int err_count = 0, checks_done = 0;
	localparam logic [11:0] RT [11] = '{{4'h0, LINK_REVISION, 4'h0}, 12'h100, 12'h200, 12'h300,
		12'h400, 12'h700, 12'h800, 12'h903, 12'ha01, 12'hb01, 12'hc00};
	localparam logic [2:0] EC [5] = '{ERR_PARITY, ERR_FRAME, ERR_CLOCK, ERR_BUS, ERR_CONTENTION};
	localparam logic [2:0] CR [4] = '{CRC_OFF, CRC_BUSY, CRC_PASS, CRC_FAIL};
	always #5 i_clk_sys = ~i_clk_sys;
	always @(posedge i_clk_sys) if (o_timeout_err === 1'b1) to_seen <= 1'b1;
	dbg_link_regs dbg_link_regs_inst (.i_clk_sys, .i_rst, .i_req, .o_rdata, .i_evt,
		.i_access_pending(pend), .i_access_done(done), .i_sys_reset_nack_evt(nack), .i_sys,
		.o_cfg, .o_link_reset, .o_timeout_err, .o_send_nack, .o_sys_reset_req,
		.o_sys_clock_request, .o_user_row_done, .o_mem_prog_ok, .o_user_row_prog_ok);
	dbg_sys_model dbg_sys_model_inst (.i_clk_sys, .i_rst, .i_reset_hold(o_sys_reset_req),
		.i_sleep(sleep), .i_unlock(unlock), .i_crc_sel(crc), .o_sys(i_sys));
	task tick(input int n = 1);
		repeat (n) @(posedge i_clk_sys);
		#1;
	endtask
	task chk(input string s, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %s exp %h seen %h", s, exp, seen);
		end
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		i_req = {1'b1, 1'b0, a, d};
		tick();
		i_req = '0;
	endtask
	// address kept after the strobe so the registered read data stays put
	task rc(input logic [3:0] a, input logic [7:0] e);
		i_req = {1'b0, 1'b1, a, 8'h00};
		tick();
		v = o_rdata;
		i_req.rd = 1'b0;
		chk($sformatf("reg %h", a), v, e);
	endtask
	task ev(input logic [11:0] e);
		i_evt = e;
		tick();
		i_evt = '0;
	endtask
	task complete_run;
		if (err_count == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		#950000;
		err_count++;
		complete_run();
	end
	initial begin
		tick(16);
		i_rst = 1'b0;
		tick(2);
		chk("guard", o_cfg.guard_cycles, GUARD_MAX_CYCLES);
		chk("clksel", {6'h0, o_cfg.link_clock_sel}, {6'h0, CLK_SEL_RESET});
		for (int k = 0; k < 11; k++) rc(RT[k][11:8], RT[k][7:0]);
		for (int k = 0; k < 8; k++) begin
			wr(ADDR_CTRL_A, {5'h17, k[2:0]});
			tick();
			chk("guard", o_cfg.guard_cycles, k == 7 ? GUARD_MAX_CYCLES : GUARD_MAX_CYCLES >> k);
		end
		chk("cfg", {o_cfg.inter_byte_delay_en, o_cfg.parity_check_off, o_cfg.timeout_check_off,
			o_cfg.response_sig_off, o_cfg.idle_gap_bits, 2'h0}, {4'hf, IBD_IDLE_BITS, 2'h0});
		rc(ADDR_CTRL_A, 8'hbf);
		ev(12'h800);
		rc(ADDR_ERR_STATUS, 8'h00);
		wr(ADDR_CTRL_A, 8'h00);
		tick();
		for (int k = 0; k < 5; k++) begin
			ev(12'h800 >> k);
			rc(ADDR_ERR_STATUS, {5'h0, EC[k]});
			rc(ADDR_ERR_STATUS, {5'h0, ERR_NONE});
		end
		wr(ADDR_CTRL_B, 8'h18);
		tick();
		rc(ADDR_CTRL_B, 8'h18);
		chk("cfgb", {6'h0, o_cfg.neg_ack_off, o_cfg.contention_check_off}, 8'h03);
		for (int k = 0; k < 2; k++) begin
			nack = 1'b1;
			tick();
			nack = 1'b0;
			chk("nack", {7'h0, o_send_nack}, {7'h0, k[0]});
			wr(ADDR_CTRL_B, 8'h00);
			tick(2);
		end
		wr(ADDR_CLK_SEL, 8'h01);
		wr(ADDR_RST_REQ, RST_CODE_RESET);
		chk("reset_request_code", {7'h0, o_sys_reset_req}, 8'h01);
		tick(3);
		rc(ADDR_SYS_STATUS, 8'h21);
		rc(ADDR_CLK_SEL, 8'h01);
		chk("clksel", {6'h0, o_cfg.link_clock_sel}, 8'h01);
		wr(ADDR_RST_REQ, RST_CODE_RUN);
		chk("reset_request_code", {7'h0, o_sys_reset_req}, 8'h00);
		tick(3);
		rc(ADDR_SYS_STATUS, 8'h21);
		rc(ADDR_SYS_STATUS, 8'h01);
		wr(ADDR_RST_REQ, 8'h5a);
		chk("reset_request_code", {7'h0, o_sys_reset_req}, 8'h00);
		sleep = 1'b1;
		unlock = 1'b1;
		tick(3);
		rc(ADDR_SYS_STATUS, 8'h10);
		sleep = 1'b0;
		for (int k = 0; k < 4; k++) begin
			crc = k[1:0];
			tick(3);
			rc(ADDR_CRC_STATUS, {5'h0, CR[k]});
		end
		rc(ADDR_SYS_STATUS, 8'h00);
		wr(ADDR_SYS_CTRL, 8'h02);
		chk("urdone", {7'h0, o_user_row_done}, 8'h00);
		chk("sys_clock_request", {7'h0, o_sys_clock_request}, 8'h00);
		wr(ADDR_SYS_CTRL, 8'h01);
		chk("sys_clock_request", {7'h0, o_sys_clock_request}, 8'h01);
		ev(12'h010);
		ev(12'h020);
		ev(12'h040);
		rc(ADDR_KEY_STATUS, 8'h38);
		ev(12'h008);
		rc(ADDR_KEY_STATUS, 8'h28);
		chk("prog", {7'h0, o_mem_prog_ok}, 8'h01);
		ev(12'h001);
		rc(ADDR_KEY_STATUS, 8'h20);
		ev(12'h004);
		rc(ADDR_SYS_STATUS, 8'h0c);
		wr(ADDR_SYS_CTRL, 8'h03);
		chk("urdone", {7'h0, o_user_row_done}, 8'h01);
		wr(ADDR_KEY_STATUS, 8'h20);
		tick();
		rc(ADDR_KEY_STATUS, 8'h00);
		chk("urowok", {7'h0, o_user_row_prog_ok}, 8'h00);
		wr(ADDR_RST_REQ, RST_CODE_RESET);
		wr(ADDR_RST_REQ, RST_CODE_RUN);
		tick();
		chk("prog", {7'h0, o_mem_prog_ok}, 8'h00);
		// a done midway must restart the count, so 70000 pending cycles stay quiet
		pend = 1'b1;
		tick(20000);
		done = 1'b1;
		tick();
		done = 1'b0;
		tick(50000);
		chk("early", {7'h0, to_seen}, 8'h00);
		tick(15600);
		chk("timeout", {7'h0, to_seen}, 8'h01);
		pend = 1'b0;
		rc(ADDR_ERR_STATUS, {5'h0, ERR_TIMEOUT});
		ev(12'h010);
		wr(ADDR_CTRL_A, 8'hbf);
		tick();
		wr(ADDR_CTRL_B, 8'h04);
		chk("linkrst", {7'h0, o_link_reset}, 8'h01);
		tick(2);
		chk("sys_clock_request", {7'h0, o_sys_clock_request}, 8'h00);
		rc(ADDR_CTRL_A, 8'h00);
		rc(ADDR_KEY_STATUS, 8'h00);
		rc(ADDR_CTRL_B, 8'h00);
		complete_run();
	end
endmodule
`default_nettype wire

// [logic/dbg_link_pkg.sv]
package dbg_link_pkg;
	localparam logic [3:0] ADDR_STATUS_REV = 4'h0;
	localparam logic [3:0] ADDR_ERR_STATUS = 4'h1;
	localparam logic [3:0] ADDR_CTRL_A = 4'h2;
	localparam logic [3:0] ADDR_CTRL_B = 4'h3;
	localparam logic [3:0] ADDR_KEY_STATUS = 4'h7;
	localparam logic [3:0] ADDR_RST_REQ = 4'h8;
	localparam logic [3:0] ADDR_CLK_SEL = 4'h9;
	localparam logic [3:0] ADDR_SYS_CTRL = 4'ha;
	localparam logic [3:0] ADDR_SYS_STATUS = 4'hb;
	localparam logic [3:0] ADDR_CRC_STATUS = 4'hc;
	// revision value is arbitrary
	localparam logic [3:0] LINK_REVISION = 4'h1;
	localparam int REV_LSB = 4;
	localparam int CA_INTER_BYTE_DELAY_EN = 7;
	localparam int CA_PARITY_CHECK_OFF = 5;
	localparam int CA_DTD = 4;
	localparam int CA_RSD = 3;
	localparam int CB_NACK = 4;
	localparam int CB_CCDET = 3;
	localparam int CB_DIS = 2;
	localparam int KS_UROW = 5;
	localparam int KS_PROG = 4;
	localparam int KS_ERASE = 3;
	localparam int SC_UROW_DONE = 1;
	localparam int SC_SYS_CLOCK_REQUEST = 0;
	localparam int SS_RST = 5;
	localparam int SS_SLEEP = 4;
	localparam int SS_PROG = 3;
	localparam int SS_UROW = 2;
	localparam int SS_LOCK = 0;
	localparam logic [7:0] CTRL_A_RESET = 8'h00;
	localparam logic [7:0] CTRL_B_RESET = 8'h00;
	localparam logic [7:0] RST_REQ_RESET = 8'h00;
	localparam logic [1:0] CLK_SEL_RESET = 2'h3;
	localparam logic [7:0] RST_CODE_RUN = 8'h00;
	localparam logic [7:0] RST_CODE_RESET = 8'h59;
	localparam logic [2:0] ERR_NONE = 3'h0;
	localparam logic [2:0] ERR_PARITY = 3'h1;
	localparam logic [2:0] ERR_FRAME = 3'h2;
	localparam logic [2:0] ERR_TIMEOUT = 3'h3;
	localparam logic [2:0] ERR_CLOCK = 3'h4;
	localparam logic [2:0] ERR_BUS = 3'h6;
	localparam logic [2:0] ERR_CONTENTION = 3'h7;
	localparam logic [2:0] GUARD_RESERVED = 3'h7;
	localparam logic [7:0] GUARD_MAX_CYCLES = 8'h80;
	localparam logic [16:0] TIMEOUT_CYCLES = 17'h10000;
	localparam logic [1:0] IBD_IDLE_BITS = 2'h2;
	localparam logic [2:0] CRC_OFF = 3'h0;
	localparam logic [2:0] CRC_BUSY = 3'h1;
	localparam logic [2:0] CRC_PASS = 3'h2;
	localparam logic [2:0] CRC_FAIL = 3'h4;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [3:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic parity_err;
		logic frame_err;
		logic clock_err;
		logic bus_err;
		logic contention_err;
		logic key_urow;
		logic key_prog;
		logic key_erase;
		logic prog_start;
		logic urow_started;
		logic urow_finished;
		logic erase_reset;
	} link_evt_t;

	typedef struct packed {
		logic sys_in_reset;
		logic sys_in_sleep;
		logic locked;
		logic crc_busy;
		logic crc_done;
		logic crc_ok;
		logic crc_enabled;
	} sys_stat_t;

	typedef struct packed {
		logic inter_byte_delay_en;
		logic parity_check_off;
		logic timeout_check_off;
		logic response_sig_off;
		logic neg_ack_off;
		logic contention_check_off;
		logic [7:0] guard_cycles;
		logic [1:0] idle_gap_bits;
		logic [1:0] link_clock_sel;
	} link_cfg_t;
endpackage

// [logic/dbg_link_regs.sv]
// Contract
// - registers reachable only via link instructions
// - upper nibble of status holds link revision
// - errors load three-bit code, read clears
// - inter-byte delay adds two idle bits
// - parity-off ignores parity, no parity errors
// - access timeout after 65536 link cycles
// - response-off suppresses response signatures
// - guard time 128 halving to 2 cycles
// - neg-ack-off suppresses nack on system reset
// - contention check runs unless bit set
// - link disable drops clock request, resets link
// - prog key flag set, cleared on start
// - erase flag set on key, cleared on reset
// - 0x59 holds reset until any other code written
// - two-bit clock select, default 4 MHz
// - user-row done writable only after key
// - clock request keeps system clock running
// - reset-active bit sticky, cleared on read
// - in-sleep bit mirrors system sleep state
// - status shows when programming may start
// - lock bit reset one, follows lock state
// - one-hot crc status field
`timescale 1ns/100ps
`default_nettype none
module dbg_link_regs (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst,
	// link-side register access, debug instructions only
	input wire dbg_link_pkg::reg_req_t i_req,
	output var logic [7:0] o_rdata,
	// link-layer events and system status
	input wire dbg_link_pkg::link_evt_t i_evt,
	input wire logic i_access_pending,
	input wire logic i_access_done,
	input wire logic i_sys_reset_nack_evt,
	input wire dbg_link_pkg::sys_stat_t i_sys,
	// configuration and control to link and system
	output var dbg_link_pkg::link_cfg_t o_cfg,
	output var logic o_link_reset,
	output var logic o_timeout_err,
	output var logic o_send_nack,
	output var logic o_sys_reset_req,
	output var logic o_sys_clock_request,
	output var logic o_user_row_done,
	output var logic o_mem_prog_ok,
	output var logic o_user_row_prog_ok
);
	import dbg_link_pkg::*;

	logic [2:0] error_code_reg, error_code_next;
	logic [7:0] ctrl_a_reg, ctrl_a_next;
	logic [7:0] ctrl_b_reg, ctrl_b_next;
	logic [2:0] key_reg, key_next;
	logic [7:0] rst_req_reg, rst_req_next;
	logic [1:0] clk_sel_reg, clk_sel_next;
	logic sys_clock_request_reg, sys_clock_request_next;
	logic urow_done_reg, urow_done_next;
	logic rst_active_reg, rst_active_next;
	logic prog_ok_reg, prog_ok_next;
	logic urow_ok_reg, urow_ok_next;
	logic lock_reg, lock_next;
	logic [16:0] tmo_cnt_reg, tmo_cnt_next;
	logic tmo_err_reg, tmo_err_next;
	logic nack_reg, nack_next;
	logic link_rst_reg, link_rst_next;
	logic [7:0] rdata_reg, rdata_next;
	logic sys_rst_reg, sys_rst_next;
	link_cfg_t cfg_reg, cfg_next;
	logic [2:0] crc_code;
	logic [7:0] guard_cycles;
	logic wr_a, wr_b, wr_k, wr_r, wr_c, wr_s, disable_wr;

	always_comb begin
		wr_a = i_req.wr && (i_req.addr == ADDR_CTRL_A);
		wr_b = i_req.wr && (i_req.addr == ADDR_CTRL_B);
		wr_k = i_req.wr && (i_req.addr == ADDR_KEY_STATUS);
		wr_r = i_req.wr && (i_req.addr == ADDR_RST_REQ);
		wr_c = i_req.wr && (i_req.addr == ADDR_CLK_SEL);
		wr_s = i_req.wr && (i_req.addr == ADDR_SYS_CTRL);
		disable_wr = wr_b && i_req.wdata[CB_DIS];
	end

	always_comb begin
		// one-hot status; reserved combos never produced
		if (!i_sys.crc_enabled) begin
			crc_code = CRC_OFF;
		end else if (i_sys.crc_busy || !i_sys.crc_done) begin
			crc_code = CRC_BUSY;
		end else if (i_sys.crc_ok) begin
			crc_code = CRC_PASS;
		end else begin
			crc_code = CRC_FAIL;
		end
		// reserved code falls back to the slowest guard to stay safe
		if (ctrl_a_reg[2:0] == GUARD_RESERVED) begin
			guard_cycles = GUARD_MAX_CYCLES;
		end else begin
			guard_cycles = GUARD_MAX_CYCLES >> ctrl_a_reg[2:0];
		end
	end

	always_comb begin
		error_code_next = error_code_reg;
		ctrl_a_next = ctrl_a_reg;
		ctrl_b_next = ctrl_b_reg;
		key_next = key_reg;
		rst_req_next = rst_req_reg;
		clk_sel_next = clk_sel_reg;
		sys_clock_request_next = sys_clock_request_reg;
		urow_done_next = 1'b0;
		rst_active_next = rst_active_reg;
		prog_ok_next = prog_ok_reg;
		urow_ok_next = urow_ok_reg;
		lock_next = i_sys.locked;
		tmo_cnt_next = tmo_cnt_reg;
		tmo_err_next = 1'b0;
		nack_next = 1'b0;
		link_rst_next = 1'b0;
		rdata_next = rdata_reg;
		// read side effects first so a same-cycle event wins
		if (i_req.rd && i_req.addr == ADDR_ERR_STATUS) begin
			error_code_next = ERR_NONE;
		end
		if (i_req.rd && i_req.addr == ADDR_SYS_STATUS) begin
			rst_active_next = 1'b0;
		end
		if (i_sys.sys_in_reset || sys_rst_reg) begin
			rst_active_next = 1'b1;
		end
		// access layer watchdog counted in system-clock (i_clk_sys) ticks
		if (!i_access_pending || i_access_done || ctrl_a_reg[CA_DTD]) begin
			tmo_cnt_next = '0;
		end else if (tmo_cnt_reg == TIMEOUT_CYCLES - 17'h1) begin
			tmo_cnt_next = '0;
			tmo_err_next = 1'b1;
		end else begin
			tmo_cnt_next = tmo_cnt_reg + 17'h1;
		end
		if (i_evt.parity_err && !ctrl_a_reg[CA_PARITY_CHECK_OFF]) begin
			error_code_next = ERR_PARITY;
		end
		if (i_evt.frame_err) begin
			error_code_next = ERR_FRAME;
		end
		if (tmo_err_next) begin
			error_code_next = ERR_TIMEOUT;
		end
		if (i_evt.clock_err) begin
			error_code_next = ERR_CLOCK;
		end
		if (i_evt.bus_err) begin
			error_code_next = ERR_BUS;
		end
		if (i_evt.contention_err && !ctrl_b_reg[CB_CCDET]) begin
			error_code_next = ERR_CONTENTION;
		end
		// gate on the published config so the nack follows what the link sees
		if (i_sys_reset_nack_evt && !cfg_reg.neg_ack_off) begin
			nack_next = 1'b1;
		end
		if (wr_a) begin
			ctrl_a_next = i_req.wdata & 8'hbf;
		end
		if (wr_b) begin
			ctrl_b_next = i_req.wdata & 8'h18;
		end
		if (wr_c) begin
			clk_sel_next = i_req.wdata[1:0];
		end
		if (wr_r) begin
			rst_req_next = i_req.wdata;
		end
		if (wr_s) begin
			sys_clock_request_next = i_req.wdata[SC_SYS_CLOCK_REQUEST];
			if (key_reg[2]) begin
				urow_done_next = i_req.wdata[SC_UROW_DONE];
			end
		end
		// debugger write to the user-row flag closes the session
		if (wr_k && i_req.wdata[KS_UROW]) begin
			key_next[2] = 1'b0;
			urow_ok_next = 1'b0;
		end
		if (i_evt.prog_start) begin
			key_next[1] = 1'b0;
			prog_ok_next = 1'b1;
		end
		if (i_evt.urow_started) begin
			urow_ok_next = 1'b1;
		end
		if (i_evt.urow_finished) begin
			urow_ok_next = 1'b0;
		end
		if (i_evt.erase_reset) begin
			key_next[0] = 1'b0;
		end
		// requesting reset (0x59) once the prog key is cleared ends the session
		if (wr_r && i_req.wdata == RST_CODE_RESET && !key_reg[1]) begin
			prog_ok_next = 1'b0;
		end
		if (i_evt.key_urow) begin
			key_next[2] = 1'b1;
		end
		if (i_evt.key_prog) begin
			key_next[1] = 1'b1;
		end
		if (i_evt.key_erase) begin
			key_next[0] = 1'b1;
		end
		// disable wipes link config and keys, system reset request untouched
		if (disable_wr) begin
			ctrl_a_next = CTRL_A_RESET;
			ctrl_b_next = CTRL_B_RESET;
			clk_sel_next = CLK_SEL_RESET;
			key_next = '0;
			sys_clock_request_next = 1'b0;
			error_code_next = ERR_NONE;
			link_rst_next = 1'b1;
		end
		case (i_req.addr)
			ADDR_STATUS_REV: rdata_next = {LINK_REVISION, 4'h0};
			ADDR_ERR_STATUS: rdata_next = {5'h00, error_code_reg};
			ADDR_CTRL_A: rdata_next = ctrl_a_reg;
			ADDR_CTRL_B: rdata_next = ctrl_b_reg;
			ADDR_KEY_STATUS: rdata_next = {2'h0, key_reg, 3'h0};
			ADDR_RST_REQ: rdata_next = rst_req_reg;
			ADDR_CLK_SEL: rdata_next = {6'h00, clk_sel_reg};
			ADDR_SYS_CTRL: rdata_next = {7'h00, sys_clock_request_reg};
			ADDR_SYS_STATUS: rdata_next = {2'h0, rst_active_reg, i_sys.sys_in_sleep,
				prog_ok_reg, urow_ok_reg, 1'b0, lock_reg};
			ADDR_CRC_STATUS: rdata_next = {5'h00, crc_code};
			default: rdata_next = 8'h00;
		endcase
		// only 0x59 asserts reset; other codes release it
		sys_rst_next = (rst_req_next == RST_CODE_RESET);
		cfg_next.inter_byte_delay_en = ctrl_a_reg[CA_INTER_BYTE_DELAY_EN];
		cfg_next.idle_gap_bits = ctrl_a_reg[CA_INTER_BYTE_DELAY_EN] ? IBD_IDLE_BITS : 2'h0;
		cfg_next.parity_check_off = ctrl_a_reg[CA_PARITY_CHECK_OFF];
		cfg_next.timeout_check_off = ctrl_a_reg[CA_DTD];
		cfg_next.response_sig_off = ctrl_a_reg[CA_RSD];
		cfg_next.guard_cycles = guard_cycles;
		cfg_next.neg_ack_off = ctrl_b_reg[CB_NACK];
		cfg_next.contention_check_off = ctrl_b_reg[CB_CCDET];
		cfg_next.link_clock_sel = clk_sel_reg;
	end

	// system reset of the chip does not reach here; i_rst is link-side only
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			error_code_reg <= ERR_NONE;
			ctrl_a_reg <= CTRL_A_RESET;
			ctrl_b_reg <= CTRL_B_RESET;
			key_reg <= 3'h0;
			rst_req_reg <= RST_REQ_RESET;
			clk_sel_reg <= CLK_SEL_RESET;
			sys_clock_request_reg <= 1'b1;
			urow_done_reg <= 1'b0;
			rst_active_reg <= 1'b0;
			prog_ok_reg <= 1'b0;
			urow_ok_reg <= 1'b0;
			lock_reg <= 1'b1;
			tmo_cnt_reg <= '0;
			tmo_err_reg <= 1'b0;
			nack_reg <= 1'b0;
			link_rst_reg <= 1'b0;
			rdata_reg <= 8'h00;
			sys_rst_reg <= 1'b0;
			cfg_reg <= '0;
		end else begin
			error_code_reg <= error_code_next;
			ctrl_a_reg <= ctrl_a_next;
			ctrl_b_reg <= ctrl_b_next;
			key_reg <= key_next;
			rst_req_reg <= rst_req_next;
			clk_sel_reg <= clk_sel_next;
			sys_clock_request_reg <= sys_clock_request_next;
			urow_done_reg <= urow_done_next;
			rst_active_reg <= rst_active_next;
			prog_ok_reg <= prog_ok_next;
			urow_ok_reg <= urow_ok_next;
			lock_reg <= lock_next;
			tmo_cnt_reg <= tmo_cnt_next;
			tmo_err_reg <= tmo_err_next;
			nack_reg <= nack_next;
			link_rst_reg <= link_rst_next;
			rdata_reg <= rdata_next;
			sys_rst_reg <= sys_rst_next;
			cfg_reg <= cfg_next;
		end
	end

	assign o_rdata = rdata_reg;
	assign o_cfg = cfg_reg;
	assign o_link_reset = link_rst_reg;
	assign o_timeout_err = tmo_err_reg;
	assign o_send_nack = nack_reg;
	assign o_sys_reset_req = sys_rst_reg;
	assign o_sys_clock_request = sys_clock_request_reg;
	assign o_user_row_done = urow_done_reg;
	assign o_mem_prog_ok = prog_ok_reg;
	assign o_user_row_prog_ok = urow_ok_reg;
endmodule
`default_nettype wire
